// >>> hw/lvdw_top.sv
`timescale 1ns/10ps
// Behaviour
// - any request flag set by hardware rising low to high wakes the device, regardless of enables; a software write setting a flag does not wake it
// - a set request flag stays set until serviced or cleared by software
// - servicing a group clears only the group flag, not the source flag
// - on interrupt entry only the program counter is pushed
// - interrupt return sets the global interrupt enable
// - plain subroutine return leaves the global interrupt enable unchanged
// - detector enable is control bit 4, read/write
// - threshold select is bits 2..0, eight levels 2.0V to 4.0V
// - detect output is read-only bit 5, high while the detector is on and supply is low
// - control bits 7, 6 and 3 read as zero
// - supply-low flag sets only after a fixed delay of detect high
// - detect output may toggle near threshold; consumer must tolerate it
// - supply-low interrupt belongs to group 3 and also wakes the device
// - supply-low flag is never cleared by servicing, only by software
// - vectoring needs global, supply-low and group 3 enables, stack not full
// - servicing any interrupt clears the global interrupt enable
module lvdw_top
    import lvdw_pkg::*;
#(
    parameter int DELAY_CYC = DETECT_TO_FLAG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_below_thr,
    output logic detector_on,
    output logic [2:0] threshold_select,
    input wire logic [2:0] member_req,
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic return_from_interrupt,
    input wire logic subroutine_return,
    input wire logic sleep_enter,
    output logic irq_req,
    output logic [1:0] irq_vector,
    output logic push_pc,
    output logic wake,
    output logic sleeping,
    output logic irq
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (DELAY_CYC < 1 || DELAY_CYC > 65535) begin : g_bad_delay
        $error("lvdw_top: DELAY_CYC out of range");
    end

    // lowest set bit of a four-bit request vector
    function automatic logic [1:0] first_set(input logic [3:0] v);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = GROUP_N - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // ----------------------------------------------------------------
    // detect delay filter
    // ----------------------------------------------------------------
    lvdw_det_if det ();

    lvdw_detect_filter #(
        .DELAY_CYC(DELAY_CYC)
    ) u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .det(det)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic detector_on_r, detector_on_nxt;
    logic [2:0] threshold_r, threshold_nxt;
    logic supply_low_irq_flag_r, supply_low_irq_flag_nxt;
    logic [3:0] group_irq_flags_r, group_irq_flags_nxt;
    logic supply_low_irq_enable_r, supply_low_irq_enable_nxt;
    logic [3:0] group_irq_enable_r, group_irq_enable_nxt;
    logic global_irq_enable_r, global_irq_enable_nxt;
    logic [2:0] evt_status_r, evt_status_nxt;
    logic [2:0] evt_mask_r, evt_mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic irq_req_r, irq_req_nxt;
    logic [1:0] irq_vector_r, irq_vector_nxt;
    logic push_pc_r, push_pc_nxt;
    logic wake_r, wake_nxt;
    logic irq_r, irq_nxt;
    lvdw_state_e state_r, state_nxt;

    logic wr_en, rd_en, hit;
    logic [3:0] group_set;
    logic flag_rise;
    logic [2:0] evt_set;
    logic [3:0] group_pend;
    logic service;
    logic [31:0] rd_val;

    // filter inputs, after the state they read
    assign det.ce = clk_en;
    assign det.enable = detector_on_r;
    assign det.level = supply_below_thr;

    // ----------------------------------------------------------------
    // apb decode and read mux
    // ----------------------------------------------------------------
    always_comb begin
        wr_en = psel & penable & pready_r & pwrite;
        rd_en = psel & penable & pready_r & ~pwrite;
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: begin
                rd_val[CTRL_THR_LSB +: CTRL_THR_W] = threshold_r;
                rd_val[CTRL_ON_BIT] = detector_on_r;
                rd_val[CTRL_OUT_BIT] = detector_on_r & supply_below_thr;
            end
            OFS_FLAGS: begin
                rd_val[FLG_SUPPLY_LOW_BIT] = supply_low_irq_flag_r;
                rd_val[FLG_GROUP_LSB +: GROUP_N] = group_irq_flags_r;
            end
            OFS_ENABLE: begin
                rd_val[FLG_SUPPLY_LOW_BIT] = supply_low_irq_enable_r;
                rd_val[FLG_GROUP_LSB +: GROUP_N] = group_irq_enable_r;
                rd_val[EN_GLOBAL_BIT] = global_irq_enable_r;
            end
            OFS_EVT_STATUS: rd_val[EVT_N-1:0] = evt_status_r;
            OFS_EVT_MASK: rd_val[EVT_N-1:0] = evt_mask_r;
            default: hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // interrupt request flags and service
    // ----------------------------------------------------------------
    always_comb begin
        supply_low_irq_flag_nxt = supply_low_irq_flag_r;
        group_irq_flags_nxt = group_irq_flags_r;
        global_irq_enable_nxt = global_irq_enable_r;
        supply_low_irq_enable_nxt = supply_low_irq_enable_r;
        group_irq_enable_nxt = group_irq_enable_r;
        detector_on_nxt = detector_on_r;
        threshold_nxt = threshold_r;
        push_pc_nxt = 1'b0;
        service = irq_ack & irq_req_r;
        // software writes: flags may be forced high or cleared
        if (wr_en && paddr == OFS_CTRL) begin
            detector_on_nxt = pwdata[CTRL_ON_BIT];
            threshold_nxt = pwdata[CTRL_THR_LSB +: CTRL_THR_W];
        end
        if (wr_en && paddr == OFS_FLAGS) begin
            supply_low_irq_flag_nxt = pwdata[FLG_SUPPLY_LOW_BIT];
            group_irq_flags_nxt = pwdata[FLG_GROUP_LSB +: GROUP_N];
        end
        if (wr_en && paddr == OFS_ENABLE) begin
            supply_low_irq_enable_nxt = pwdata[FLG_SUPPLY_LOW_BIT];
            group_irq_enable_nxt = pwdata[FLG_GROUP_LSB +: GROUP_N];
            global_irq_enable_nxt = pwdata[EN_GLOBAL_BIT];
        end
        // servicing clears the group flag and the global enable only
        if (service) begin
            group_irq_flags_nxt[irq_vector_r] = 1'b0;
            global_irq_enable_nxt = 1'b0;
            push_pc_nxt = 1'b1;
        end
        if (return_from_interrupt) begin
            global_irq_enable_nxt = 1'b1;
        end
        // a plain return leaves the global enable as it is
        if (subroutine_return && !return_from_interrupt) begin
            global_irq_enable_nxt = global_irq_enable_nxt;
        end
        // hardware sets win over any clear in the same cycle
        group_set = {det.flag_set & supply_low_irq_enable_r, member_req};
        if (det.flag_set) begin
            supply_low_irq_flag_nxt = 1'b1;
        end
        group_irq_flags_nxt = group_irq_flags_nxt | group_set;
    end

    // ----------------------------------------------------------------
    // vector request, wake-up, power state and events
    // ----------------------------------------------------------------
    always_comb begin
        flag_rise = (det.flag_set & ~supply_low_irq_flag_r)
            | (|(group_set & ~group_irq_flags_r));
        group_pend = group_irq_flags_nxt & group_irq_enable_nxt;
        if (!supply_low_irq_enable_nxt) begin
            group_pend[GROUP_SUPPLY_LOW] = 1'b0;
        end
        irq_req_nxt = global_irq_enable_nxt & ~stack_full & (|group_pend);
        irq_vector_nxt = first_set(group_pend);
        wake_nxt = flag_rise;
        state_nxt = state_r;
        unique case (state_r)
            LVDW_RUN: begin
                if (sleep_enter && !flag_rise) begin
                    state_nxt = LVDW_SLEEP;
                end
            end
            LVDW_SLEEP: begin
                if (flag_rise) begin
                    state_nxt = LVDW_RUN;
                end
            end
        endcase
        evt_set = 3'h0;
        evt_set[EVT_DETECT_RISE] = det.rise;
        evt_set[EVT_FLAG_SET] = det.flag_set;
        evt_set[EVT_WAKE] = flag_rise;
        evt_status_nxt = evt_status_r;
        evt_mask_nxt = evt_mask_r;
        if (rd_en && paddr == OFS_EVT_STATUS) begin
            evt_status_nxt = 3'h0;
        end
        if (wr_en && paddr == OFS_EVT_MASK) begin
            evt_mask_nxt = pwdata[EVT_N-1:0];
        end
        evt_status_nxt = evt_status_nxt | evt_set;
        irq_nxt = |(evt_status_nxt & evt_mask_nxt);
        // apb answer: one wait-free access phase after each setup
        pready_nxt = psel & ~penable & ~pready_r;
        prdata_nxt = (psel & ~penable) ? rd_val : prdata_r;
        pslverr_nxt = psel & ~penable & ~hit;
    end

    // ----------------------------------------------------------------
    // registers, frozen while the clock enable is low
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detector_on_r <= RST_DETECTOR_ON;
            threshold_r <= RST_THRESHOLD;
            supply_low_irq_flag_r <= 1'b0;
            group_irq_flags_r <= RST_GROUP;
            supply_low_irq_enable_r <= 1'b0;
            group_irq_enable_r <= RST_GROUP;
            global_irq_enable_r <= 1'b0;
            evt_status_r <= RST_EVT;
            evt_mask_r <= RST_EVT;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_req_r <= 1'b0;
            irq_vector_r <= 2'h0;
            push_pc_r <= 1'b0;
            wake_r <= 1'b0;
            irq_r <= 1'b0;
            state_r <= LVDW_RUN;
        end else if (clk_en) begin
            detector_on_r <= detector_on_nxt;
            threshold_r <= threshold_nxt;
            supply_low_irq_flag_r <= supply_low_irq_flag_nxt;
            group_irq_flags_r <= group_irq_flags_nxt;
            supply_low_irq_enable_r <= supply_low_irq_enable_nxt;
            group_irq_enable_r <= group_irq_enable_nxt;
            global_irq_enable_r <= global_irq_enable_nxt;
            evt_status_r <= evt_status_nxt;
            evt_mask_r <= evt_mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_req_r <= irq_req_nxt;
            irq_vector_r <= irq_vector_nxt;
            push_pc_r <= push_pc_nxt;
            wake_r <= wake_nxt;
            irq_r <= irq_nxt;
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign detector_on = detector_on_r;
    assign threshold_select = threshold_r;
    assign irq_req = irq_req_r;
    assign irq_vector = irq_vector_r;
    assign push_pc = push_pc_r;
    assign wake = wake_r;
    assign sleeping = (state_r == LVDW_SLEEP);
    assign irq = irq_r;

endmodule

// >>> hw/lvdw_pkg.sv
package lvdw_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h0C;
    localparam logic [7:0] OFS_EVT_MASK = 8'h10;

    // ----------------------------------------------------------------
    // low_voltage_detect_control fields
    // ----------------------------------------------------------------
    localparam int CTRL_THR_LSB = 0;
    localparam int CTRL_THR_W = 3;
    localparam int CTRL_ON_BIT = 4;
    localparam int CTRL_OUT_BIT = 5;
    localparam logic [2:0] RST_THRESHOLD = 3'h0;
    localparam logic RST_DETECTOR_ON = 1'b0;

    // ----------------------------------------------------------------
    // flag and enable register fields
    // ----------------------------------------------------------------
    localparam int FLG_SUPPLY_LOW_BIT = 0;
    localparam int FLG_GROUP_LSB = 4;
    localparam int GROUP_N = 4;
    localparam int GROUP_SUPPLY_LOW = 3;
    localparam int EN_GLOBAL_BIT = 8;
    localparam logic [3:0] RST_GROUP = 4'h0;

    // ----------------------------------------------------------------
    // event status / mask fields
    // ----------------------------------------------------------------
    localparam int EVT_N = 3;
    localparam int EVT_DETECT_RISE = 0;
    localparam int EVT_FLAG_SET = 1;
    localparam int EVT_WAKE = 2;
    localparam logic [2:0] RST_EVT = 3'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int DETECT_TO_FLAG_DELAY_NS = 10000;
    localparam int DETECT_TO_FLAG_CYC =
        (DETECT_TO_FLAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // power state
    // ----------------------------------------------------------------
    typedef enum logic {
        LVDW_RUN = 1'b0,
        LVDW_SLEEP = 1'b1
    } lvdw_state_e;

endpackage

// >>> hw/lvdw_det_if.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// link between the register core and the detect delay filter
// ----------------------------------------------------------------
interface lvdw_det_if;
    logic ce;
    logic enable;
    logic level;
    logic rise;
    logic flag_set;
    modport filt (input ce, input enable, input level, output rise, output flag_set);
    modport ctrl (output ce, output enable, output level, input rise, input flag_set);
endinterface

// >>> hw/lvdw_detect_filter.sv
`timescale 1ns/10ps
module lvdw_detect_filter
    import lvdw_pkg::*;
#(
    parameter int DELAY_CYC = DETECT_TO_FLAG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    lvdw_det_if.filt det
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (DELAY_CYC < 1 || DELAY_CYC > 65535) begin : g_bad_delay
        $error("lvdw_detect_filter: DELAY_CYC out of range");
    end

    logic [15:0] cnt_r, cnt_nxt;
    logic prev_r, prev_nxt;
    logic done_r, done_nxt;
    logic rise_r, rise_nxt;
    logic set_r, set_nxt;

    // ----------------------------------------------------------------
    // delay count: restarts on every drop so fast toggling is filtered
    // ----------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        prev_nxt = det.enable & det.level;
        rise_nxt = det.enable & det.level & ~prev_r;
        set_nxt = 1'b0;
        if (!(det.enable && det.level)) begin
            cnt_nxt = 16'h0000;
            done_nxt = 1'b0;
        end else if (!done_r) begin
            if (cnt_r == 16'(DELAY_CYC - 1)) begin
                set_nxt = 1'b1;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
    end

    // registers, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            prev_r <= 1'b0;
            done_r <= 1'b0;
            rise_r <= 1'b0;
            set_r <= 1'b0;
        end else if (det.ce) begin
            cnt_r <= cnt_nxt;
            prev_r <= prev_nxt;
            done_r <= done_nxt;
            rise_r <= rise_nxt;
            set_r <= set_nxt;
        end
    end

    assign det.rise = rise_r & det.ce;
    assign det.flag_set = set_r & det.ce;

endmodule

// >>> test/lvdw_asserts.sv
`timescale 1ns/10ps
module lvdw_asserts
    import lvdw_pkg::*;
#(
    parameter int DELAY_CYC = DETECT_TO_FLAG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic detector_on,
    input wire logic [2:0] threshold_select,
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic push_pc,
    input wire logic wake,
    input wire logic sleeping
);
    // ------------------------------------------------
    // checks on the register bus and core handshake
    // ------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic unmapped;
    // address decode seen from outside
    assign unmapped = !(paddr inside {OFS_CTRL, OFS_FLAGS, OFS_ENABLE, OFS_EVT_STATUS, OFS_EVT_MASK});
    sequence s_ack;
        clk_en && irq_ack && irq_req;
    endsequence
    sequence s_push;
        push_pc ##1 !push_pc;
    endsequence
    a_zero_wait: assert property (clk_en && psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_one: assert property (clk_en && pready |=> !pready)
        else $error("pready held too long");
    a_err_decode: assert property (clk_en && psel && !penable |=> pslverr == $past(unmapped))
        else $error("pslverr does not match decode");
    a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_ctrl_zeros: assert property (pready && !pwrite && paddr == OFS_CTRL |->
        prdata[31:6] == 26'h0 && !prdata[3]) else $error("control reserved bits not zero");
    a_ctrl_out: assert property (clk_en && pready && pwrite && paddr == OFS_CTRL |=>
        threshold_select == $past(pwdata[2:0]) && detector_on == $past(pwdata[4]))
        else $error("control outputs do not follow write");
    a_service_push: assert property (s_ack |=> s_push)
        else $error("service did not push once");
    a_push_cause: assert property ($rose(push_pc) |-> $past(irq_ack && irq_req && clk_en))
        else $error("push without accepted service");
    a_stack_block: assert property ((clk_en && stack_full) [*2] |-> !irq_req)
        else $error("request with stack full");
    a_wake_run: assert property (wake |-> ##[0:1] !sleeping)
        else $error("wake left device asleep");
endmodule

bind lvdw_top lvdw_asserts #(.DELAY_CYC(DELAY_CYC)) u_asserts (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .detector_on(detector_on), .threshold_select(threshold_select),
    .stack_full(stack_full), .irq_ack(irq_ack), .irq_req(irq_req), .push_pc(push_pc),
    .wake(wake), .sleeping(sleeping)
);

// >>> test/lvdw_top_test.sv
`timescale 1ns/10ps
module lvdw_top_test;
    import lvdw_pkg::*;
    localparam int D = 12;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0] member_req, threshold_select;
    logic [1:0] irq_vector;
    logic supply_below_thr, detector_on, stack_full, irq_ack, return_from_interrupt;
    logic subroutine_return, sleep_enter, irq_req, push_pc, wake, sleeping, irq;
    logic [32:0] exp_q[$];
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 32'heb1a37d6;
    int n;

    lvdw_top #(.DELAY_CYC(D)) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_below_thr(supply_below_thr), .detector_on(detector_on),
        .threshold_select(threshold_select), .member_req(member_req), .stack_full(stack_full),
        .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
        .subroutine_return(subroutine_return), .sleep_enter(sleep_enter), .irq_req(irq_req),
        .irq_vector(irq_vector), .push_pc(push_pc), .wake(wake), .sleeping(sleeping), .irq(irq)
    );

    // clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_wake(output int k);
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (wake !== 1'b1 && k < 60);
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // read monitor takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("apb read", exp_q.pop_front(), {pslverr, prdata});
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, stack_full, irq_ack, return_from_interrupt} = '0;
        {subroutine_return, sleep_enter, paddr, pwdata, member_req, supply_below_thr} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CTRL, 33'h0);
        rd(OFS_FLAGS, 33'h0);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            wr(OFS_CTRL, {r[31:3], i[2:0]});
            rd(OFS_CTRL, {28'h0, r[4], 1'b0, i[2:0]});
            chk("threshold_select", i[2:0], threshold_select);
            chk("detector_on", r[4], detector_on);
        end
        for (int j = 0; j < 4; j++) begin
            wr(OFS_CTRL, {27'h0, j[1], 4'h0});
            supply_below_thr <= j[0];
            @(posedge pclk);
            rd(OFS_CTRL, {27'h0, j[1] & j[0], j[1], 4'h0});
            supply_below_thr <= 1'b0;
        end
        wr(OFS_ENABLE, 32'h1);
        wr(OFS_EVT_MASK, 32'h7);
        wr(OFS_CTRL, 32'h13);
        repeat (D) @(posedge pclk);
        @(posedge pclk) sleep_enter <= 1'b1;
        @(posedge pclk) sleep_enter <= 1'b0;
        @(posedge pclk) supply_below_thr <= 1'b1;
        repeat (D - 1) @(posedge pclk);
        supply_below_thr <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("sleeping", 1'b1, sleeping);
        rd(OFS_FLAGS, 33'h0);
        @(posedge pclk) supply_below_thr <= 1'b1;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
        wait_wake(n);
        chk("flag delay", 1'b1, n + 6 == D + 5);
        supply_below_thr <= 1'b0;
        @(posedge pclk);
        chk("sleeping", 1'b0, sleeping);
        rd(OFS_FLAGS, 33'h81);
        stack_full <= 1'b1;
        wr(OFS_ENABLE, 32'h181);
        repeat (3) @(posedge pclk);
        chk("irq_req", 1'b0, irq_req);
        stack_full <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq_req", 1'b1, irq_req);
        chk("irq_vector", 2'h3, irq_vector);
        @(posedge pclk) irq_ack <= 1'b1;
        @(posedge pclk) irq_ack <= 1'b0;
        @(negedge pclk) chk("push_pc", 1'b1, push_pc);
        rd(OFS_FLAGS, 33'h01);
        rd(OFS_ENABLE, 33'h081);
        chk("irq_req", 1'b0, irq_req);
        @(posedge pclk) subroutine_return <= 1'b1;
        @(posedge pclk) subroutine_return <= 1'b0;
        rd(OFS_ENABLE, 33'h081);
        @(posedge pclk) return_from_interrupt <= 1'b1;
        @(posedge pclk) return_from_interrupt <= 1'b0;
        rd(OFS_ENABLE, 33'h181);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk) member_req <= 3'h1 << i;
            @(posedge pclk) member_req <= 3'h0;
            wait_wake(n);
            chk("wake", 1'b1, n < 5);
        end
        rd(OFS_FLAGS, 33'h71);
        wr(OFS_FLAGS, 32'hF1);
        @(posedge pclk) sleep_enter <= 1'b1;
        @(posedge pclk) sleep_enter <= 1'b0;
        @(posedge pclk) member_req <= 3'h7;
        @(posedge pclk) member_req <= 3'h0;
        repeat (4) @(posedge pclk);
        chk("sleeping", 1'b1, sleeping);
        wr(OFS_FLAGS, 32'h0);
        rd(OFS_FLAGS, 33'h0);
        @(posedge pclk) member_req <= 3'h2;
        @(posedge pclk) member_req <= 3'h0;
        wait_wake(n);
        @(posedge pclk);
        chk("sleeping", 1'b0, sleeping);
        chk("irq", 1'b1, irq);
        rd(OFS_EVT_STATUS, 33'h7);
        repeat (2) @(posedge pclk);
        chk("irq", 1'b0, irq);
        rd(OFS_EVT_STATUS, 33'h0);
        wr(OFS_EVT_MASK, 32'h0);
        @(posedge pclk) member_req <= 3'h4;
        @(posedge pclk) member_req <= 3'h0;
        repeat (4) @(posedge pclk);
        chk("irq", 1'b0, irq);
        rd(OFS_EVT_STATUS, 33'h4);
        rd(8'h14, {1'b1, 32'h0});
        wrap_up();
    end
endmodule
